// [hw/rbdw_pkg.sv]
// constants and types shared by both ends of the rom bank and data window link
// assumes a single 25 MHz clock and an 8-bit core with a 12-bit program counter
package rbdw_pkg;
  // widths of the core-side addresses and data
  localparam int PC_W = 12;
  localparam int DA_W = 8;
  localparam int DW = 8;
  localparam int BANK_OFS_W = 11;
  localparam int PAGE_W = 4;
  localparam int WIN_OFS_W = 6;
  localparam int WIN_BASE_W = 8;
  // physical rom: largest configuration, user part and test part
  localparam int ROM_AW = 15;
  localparam int ROM_BYTES = 20480;
  localparam int USER_ROM_BYTES = 20140;
  localparam int TEST_ROM_BYTES = 340;
  // other data space residents, served outside this block
  localparam int RAM_BYTES = 256;
  localparam int EEPROM_BYTES = 384;
  // page coding
  localparam logic [3:0] STATIC_PAGE = 4'h1;
  localparam logic [3:0] LAST_PAGE = 4'h9;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam logic [7:0] PAGE_CODE_MASK = 8'h0f;
  // data space map
  localparam logic [7:0] WINDOW_FIRST = 8'h40;
  localparam logic [7:0] WINDOW_LAST = 8'h7f;
  localparam logic [7:0] WINDOW_REG_ADDR = 8'hc9;
  localparam logic [7:0] PAGE_REG_ADDR = 8'hca;
  localparam logic [7:0] WINDOW_RESET = 8'h00;
  localparam logic [7:0] UNDEF_BYTE = 8'hff;
  // controller registers on apb, byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RDATA_OFS = 8'h10;
  localparam logic [7:0] IMAGE_OFS = 8'h14;
  // status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_CLAIM = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_FAULT = 3;
  // image register field positions
  localparam int IMG_PAGE_LSB = 0;
  localparam int IMG_WIN_LSB = 8;
  // operation codes in ctrl[1:0]; the fourth code is refused
  localparam logic [1:0] OP_CODE_BAD = 2'h3;
  typedef enum logic [1:0] {OP_FETCH, OP_READ, OP_WRITE} rbdw_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} rbdw_state_t;
endpackage : rbdw_pkg

// [hw/rbdw_if.sv]
// link between the core end and the rom mapping end
// assumes both ends run on the same clock; every request is answered one cycle later
`timescale 1ns/1ns
interface rbdw_if;
  // instruction fetch group
  logic fetch_req;
  logic [rbdw_pkg::PC_W-1:0] program_counter;
  logic fetch_ack;
  logic [rbdw_pkg::DW-1:0] fetch_data;
  logic fetch_fault;
  // data space group
  logic data_req;
  logic data_we;
  logic [rbdw_pkg::DA_W-1:0] data_addr;
  logic [rbdw_pkg::DW-1:0] data_wdata;
  logic [rbdw_pkg::DW-1:0] data_rdata;
  logic data_ack;
  logic data_claim;

  modport dev (
    input fetch_req, program_counter, data_req, data_we, data_addr, data_wdata,
    output fetch_ack, fetch_data, fetch_fault, data_rdata, data_ack, data_claim
  );
  modport core (
    output fetch_req, program_counter, data_req, data_we, data_addr, data_wdata,
    input fetch_ack, fetch_data, fetch_fault, data_rdata, data_ack, data_claim
  );
endinterface : rbdw_if

// [hw/rbdw_rom.sv]
// two read port rom with a load port, used by the mapping end
// assumes contents are loaded before use; reads beyond the depth return 8'hff
`timescale 1ns/1ns
module rbdw_rom #(
  parameter int DEPTH = rbdw_pkg::ROM_BYTES,
  parameter int AW = rbdw_pkg::ROM_AW
) (
  input wire logic clk,
  input wire logic load_en,
  input wire logic [AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [AW-1:0] addr_a,
  output logic [7:0] data_a,
  input wire logic [AW-1:0] addr_b,
  output logic [7:0] data_b
);
  logic [7:0] mem [DEPTH];

  // load and synchronous reads, out of range reads answer a fixed byte
  always_ff @(posedge clk) begin
    if (load_en && (load_addr < AW'(DEPTH))) begin
      mem[load_addr] <= load_data;
    end
    data_a <= (addr_a < AW'(DEPTH)) ? mem[addr_a] : rbdw_pkg::UNDEF_BYTE;
    data_b <= (addr_b < AW'(DEPTH)) ? mem[addr_b] : rbdw_pkg::UNDEF_BYTE;
  end
endmodule : rbdw_rom

// [hw/rbdw_dev.sv]
// rom page banking and data rom window, the device end of the link
// assumes the core end keeps its own software discipline; one clock, async low reset
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module rbdw_dev #(
  parameter int ROM_DEPTH = rbdw_pkg::ROM_BYTES
) (
  // clock and asynchronous low reset
  input wire logic pclk,
  input wire logic presetn,
  // link to the core end
  rbdw_if.dev link,
  // rom image load, one byte per cycle
  input wire logic rom_load_en,
  input wire logic [rbdw_pkg::ROM_AW-1:0] rom_load_addr,
  input wire logic [rbdw_pkg::DW-1:0] rom_load_data,
  // mapping state seen from the user side
  output logic [rbdw_pkg::PAGE_W-1:0] page_code_bits,
  output logic [rbdw_pkg::WIN_BASE_W-1:0] window_base_bits,
  output logic page_loaded,
  output logic window_loaded,
  output logic test_area_hit
);
  // all state of the mapping end
  typedef struct packed {
    logic [rbdw_pkg::PAGE_W-1:0] page;
    logic [rbdw_pkg::WIN_BASE_W-1:0] window;
    logic page_loaded;
    logic window_loaded;
    logic fetch_ack;
    logic fetch_fault;
    logic data_ack;
    logic data_claim;
    logic rd_window;
    logic test_hit;
  } rbdw_dev_state_t;

  localparam rbdw_dev_state_t RESET_STATE = '{
    page: rbdw_pkg::PAGE_RESET,
    window: rbdw_pkg::WINDOW_RESET,
    page_loaded: 1'b0,
    window_loaded: 1'b0,
    fetch_ack: 1'b0,
    fetch_fault: 1'b0,
    data_ack: 1'b0,
    data_claim: 1'b0,
    rd_window: 1'b0,
    test_hit: 1'b0
  };

  rbdw_dev_state_t s_q;
  rbdw_dev_state_t s_d;

  logic pc_top_bit;
  logic [rbdw_pkg::PAGE_W-1:0] eff_page;
  logic [rbdw_pkg::ROM_AW-1:0] fetch_addr;
  logic [rbdw_pkg::ROM_AW-1:0] window_addr;
  logic page_bad;
  logic in_window;
  logic [rbdw_pkg::DW-1:0] rom_a;
  logic [rbdw_pkg::DW-1:0] rom_b;

  // window decode, used for read steering and for the claim decode
  function automatic logic window_hit(input logic [rbdw_pkg::DA_W-1:0] a);
    window_hit = (a >= rbdw_pkg::WINDOW_FIRST) && (a <= rbdw_pkg::WINDOW_LAST);
  endfunction : window_hit

  // addresses this block answers; ram, eeprom and other registers live elsewhere
  function automatic logic claimed(input logic [rbdw_pkg::DA_W-1:0] a);
    if (window_hit(a)) begin
      claimed = 1'b1;
    end else if (a == rbdw_pkg::WINDOW_REG_ADDR) begin
      claimed = 1'b1;
    end else if (a == rbdw_pkg::PAGE_REG_ADDR) begin
      claimed = 1'b1;
    end else begin
      claimed = 1'b0;
    end
  endfunction : claimed

  // a code names a page only up to nine; higher codes reach no rom
  function automatic logic page_known(input logic [rbdw_pkg::PAGE_W-1:0] code);
    page_known = (code <= rbdw_pkg::LAST_PAGE);
  endfunction : page_known

  // page number on top of the eleven offset bits of the program counter
  function automatic logic [rbdw_pkg::ROM_AW-1:0] fetch_phys(
    input logic [rbdw_pkg::PAGE_W-1:0] page,
    input logic [rbdw_pkg::PC_W-1:0] prog_addr
  );
    fetch_phys = {page, prog_addr[rbdw_pkg::BANK_OFS_W-1:0]};
  endfunction : fetch_phys

  // window base as upper bits, six low data address bits below
  function automatic logic [rbdw_pkg::ROM_AW-1:0] window_phys(
    input logic [rbdw_pkg::WIN_BASE_W-1:0] base,
    input logic [rbdw_pkg::DA_W-1:0] a
  );
    // top bit held at zero, so the window stays in the first 16k bytes
    window_phys = {1'b0, base, a[rbdw_pkg::WIN_OFS_W-1:0]};
  endfunction : window_phys

  // bytes past the user area belong to the test area
  function automatic logic test_area(input logic [rbdw_pkg::ROM_AW-1:0] phys);
    test_area = (phys >= rbdw_pkg::ROM_AW'(rbdw_pkg::USER_ROM_BYTES));
  endfunction : test_area

  // program address translation
  assign pc_top_bit = link.program_counter[rbdw_pkg::PC_W-1];
  // the upper half always lands on the static page, which is page 1 in rom
  assign eff_page = pc_top_bit ? rbdw_pkg::STATIC_PAGE : s_q.page;
  // lower half uses the page code, binary page number
  assign fetch_addr = fetch_phys(eff_page, link.program_counter);
  // codes above nine name no page
  assign page_bad = !pc_top_bit && !page_known(s_q.page);

  // data rom window decode and address
  assign window_addr = window_phys(s_q.window, link.data_addr);
  assign in_window = window_hit(link.data_addr);

  // physical rom holding program and read-only data
  rbdw_rom #(
    .DEPTH(ROM_DEPTH),
    .AW(rbdw_pkg::ROM_AW)
  ) u_rom (
    .clk(pclk),
    .load_en(rom_load_en),
    .load_addr(rom_load_addr),
    .load_data(rom_load_data),
    .addr_a(fetch_addr),
    .data_a(rom_a),
    .addr_b(window_addr),
    .data_b(rom_b)
  );

  // next state: register writes, acknowledges and read steering
  always_comb begin
    s_d = s_q;
    // every request is answered on the following edge
    s_d.fetch_ack = link.fetch_req;
    s_d.data_ack = link.data_req;
    // fetch answer flags, held until the next fetch
    if (link.fetch_req) begin
      s_d.fetch_fault = page_bad;
      // a faulted fetch reaches no rom byte, so no test area either
      s_d.test_hit = !page_bad && test_area(fetch_addr);
    end
    // data answer flags, held until the next data access
    if (link.data_req) begin
      s_d.data_claim = claimed(link.data_addr);
      // only reads through the window carry rom bytes
      s_d.rd_window = !link.data_we && in_window;
    end
    if (link.data_req && link.data_we) begin
      if (link.data_addr == rbdw_pkg::WINDOW_REG_ADDR) begin
        // whole byte, used from the next access on
        s_d.window = link.data_wdata;
        s_d.window_loaded = 1'b1;
      end else if (link.data_addr == rbdw_pkg::PAGE_REG_ADDR) begin
        // only the low four bits are kept; upper bits are the writer's duty
        s_d.page = link.data_wdata[rbdw_pkg::PAGE_W-1:0];
        s_d.page_loaded = 1'b1;
      end
    end
  end

  // state register; content before the first write is not meaningful to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // answers, one cycle after each request
  assign link.fetch_ack = s_q.fetch_ack;
  assign link.fetch_fault = s_q.fetch_fault;
  assign link.fetch_data = s_q.fetch_fault ? rbdw_pkg::UNDEF_BYTE : rom_a;
  assign link.data_ack = s_q.data_ack;
  assign link.data_claim = s_q.data_claim;
  // write-only registers and unclaimed addresses read as a fixed byte
  assign link.data_rdata = s_q.rd_window ? rom_b : rbdw_pkg::UNDEF_BYTE;

  // user side view of the mapping state
  assign page_code_bits = s_q.page;
  assign window_base_bits = s_q.window;
  assign page_loaded = s_q.page_loaded;
  assign window_loaded = s_q.window_loaded;
  assign test_area_hit = s_q.test_hit;
endmodule : rbdw_dev

// [hw/rbdw_core_end.sv]
// core end of the link: apb slave that turns software orders into fetches and data accesses
// assumes an apb master on the same clock; one order outstanding at a time
`timescale 1ns/1ns
module rbdw_core_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rbdw_if.core link
);
  // all state of the core end
  typedef struct packed {
    rbdw_pkg::rbdw_state_t state;
    rbdw_pkg::rbdw_op_t op;
    logic [rbdw_pkg::PC_W-1:0] addr;
    logic [rbdw_pkg::DW-1:0] wdata;
    logic [rbdw_pkg::DW-1:0] rdata;
    logic claim;
    logic refused;
    logic fault;
    logic in_bank;
    logic [rbdw_pkg::PAGE_W-1:0] page_image;
    logic [rbdw_pkg::WIN_BASE_W-1:0] window_image;
  } rbdw_core_state_t;

  rbdw_core_state_t s_q;
  rbdw_core_state_t s_d;
  logic wr_acc;
  logic mapped;
  logic [1:0] op_code;
  logic to_page;
  logic to_window;

  assign wr_acc = psel && penable && pwrite;
  assign op_code = pwdata[1:0];
  assign to_page = s_q.addr[rbdw_pkg::DA_W-1:0] == rbdw_pkg::PAGE_REG_ADDR;
  assign to_window = s_q.addr[rbdw_pkg::DA_W-1:0] == rbdw_pkg::WINDOW_REG_ADDR;

  // next state: order intake and the request sequence
  always_comb begin
    s_d = s_q;
    if (wr_acc) begin
      if (paddr == rbdw_pkg::ADDR_OFS) begin
        s_d.addr = pwdata[rbdw_pkg::PC_W-1:0];
      end else if (paddr == rbdw_pkg::WDATA_OFS) begin
        s_d.wdata = pwdata[rbdw_pkg::DW-1:0];
      end else if (paddr == rbdw_pkg::IMAGE_OFS && s_q.state == rbdw_pkg::ST_IDLE) begin
        s_d.page_image = pwdata[rbdw_pkg::IMG_PAGE_LSB +: rbdw_pkg::PAGE_W];
        s_d.window_image = pwdata[rbdw_pkg::IMG_WIN_LSB +: rbdw_pkg::WIN_BASE_W];
      end else if (paddr == rbdw_pkg::CTRL_OFS && s_q.state == rbdw_pkg::ST_IDLE) begin
        s_d.refused = 1'b0;
        if (op_code == rbdw_pkg::OP_CODE_BAD) begin
          s_d.refused = 1'b1;
        end else if (rbdw_pkg::rbdw_op_t'(op_code) == rbdw_pkg::OP_WRITE && to_page
                     && s_q.in_bank) begin
          // page changes only while running from the static half
          s_d.refused = 1'b1;
        end else begin
          s_d.op = rbdw_pkg::rbdw_op_t'(op_code);
          s_d.state = rbdw_pkg::ST_ISSUE;
          if (rbdw_pkg::rbdw_op_t'(op_code) == rbdw_pkg::OP_WRITE && to_page) begin
            // upper bits forced to zero, ram image updated before the register
            s_d.wdata = s_q.wdata & rbdw_pkg::PAGE_CODE_MASK;
            s_d.page_image = s_q.wdata[rbdw_pkg::PAGE_W-1:0];
          end else if (rbdw_pkg::rbdw_op_t'(op_code) == rbdw_pkg::OP_WRITE && to_window) begin
            s_d.window_image = s_q.wdata;
          end
        end
      end
    end
    case (s_q.state)
      rbdw_pkg::ST_ISSUE: begin
        s_d.state = rbdw_pkg::ST_WAIT;
      end
      rbdw_pkg::ST_WAIT: begin
        if (s_q.op == rbdw_pkg::OP_FETCH && link.fetch_ack) begin
          s_d.rdata = link.fetch_data;
          s_d.fault = link.fetch_fault;
          s_d.in_bank = !s_q.addr[rbdw_pkg::PC_W-1];
          s_d.state = rbdw_pkg::ST_IDLE;
        end else if (s_q.op != rbdw_pkg::OP_FETCH && link.data_ack) begin
          s_d.rdata = link.data_rdata;
          s_d.claim = link.data_claim;
          s_d.state = rbdw_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // link drive; data writes are always whole bytes, never read-modify-write
  assign link.fetch_req = s_q.state == rbdw_pkg::ST_ISSUE && s_q.op == rbdw_pkg::OP_FETCH;
  assign link.data_req = s_q.state == rbdw_pkg::ST_ISSUE && s_q.op != rbdw_pkg::OP_FETCH;
  assign link.data_we = s_q.op == rbdw_pkg::OP_WRITE;
  assign link.program_counter = s_q.addr;
  assign link.data_addr = s_q.addr[rbdw_pkg::DA_W-1:0];
  assign link.data_wdata = s_q.wdata;

  // apb answers with no wait states
  assign mapped = (paddr == rbdw_pkg::CTRL_OFS) || (paddr == rbdw_pkg::ADDR_OFS)
    || (paddr == rbdw_pkg::WDATA_OFS) || (paddr == rbdw_pkg::STATUS_OFS)
    || (paddr == rbdw_pkg::RDATA_OFS) || (paddr == rbdw_pkg::IMAGE_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read mux over the register flops
  always_comb begin
    prdata = 32'h0;
    if (paddr == rbdw_pkg::ADDR_OFS) begin
      prdata[rbdw_pkg::PC_W-1:0] = s_q.addr;
    end else if (paddr == rbdw_pkg::WDATA_OFS) begin
      prdata[rbdw_pkg::DW-1:0] = s_q.wdata;
    end else if (paddr == rbdw_pkg::STATUS_OFS) begin
      prdata[rbdw_pkg::STAT_BUSY] = s_q.state != rbdw_pkg::ST_IDLE;
      prdata[rbdw_pkg::STAT_CLAIM] = s_q.claim;
      prdata[rbdw_pkg::STAT_REFUSED] = s_q.refused;
      prdata[rbdw_pkg::STAT_FAULT] = s_q.fault;
    end else if (paddr == rbdw_pkg::RDATA_OFS) begin
      prdata[rbdw_pkg::DW-1:0] = s_q.rdata;
    end else if (paddr == rbdw_pkg::IMAGE_OFS) begin
      prdata[rbdw_pkg::IMG_PAGE_LSB +: rbdw_pkg::PAGE_W] = s_q.page_image;
      prdata[rbdw_pkg::IMG_WIN_LSB +: rbdw_pkg::WIN_BASE_W] = s_q.window_image;
    end
  end
endmodule : rbdw_core_end

// [bench/rbdw_link_properties.sv]
// checker for the link between the core end and the rom mapping end
// assumes one clock pclk and async active-low presetn; instantiated beside the interface
`timescale 1ns/1ns
module rbdw_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic [rbdw_pkg::PC_W-1:0] program_counter,
  input wire logic fetch_ack,
  input wire logic [rbdw_pkg::DW-1:0] fetch_data,
  input wire logic fetch_fault,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [rbdw_pkg::DA_W-1:0] data_addr,
  input wire logic [rbdw_pkg::DW-1:0] data_rdata,
  input wire logic data_ack,
  input wire logic data_claim
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic in_win;
  logic in_reg;
  // data side address decode
  assign in_win = data_addr >= rbdw_pkg::WINDOW_FIRST && data_addr <= rbdw_pkg::WINDOW_LAST;
  assign in_reg = data_addr == rbdw_pkg::WINDOW_REG_ADDR || data_addr == rbdw_pkg::PAGE_REG_ADDR;
  // answers follow requests by one cycle
  a_fetch_ack_follows: assert property (fetch_req |=> fetch_ack)
    else $error("fetch not answered next cycle");
  a_fetch_ack_only: assert property (!fetch_req |=> !fetch_ack)
    else $error("fetch answer without request");
  a_data_ack_follows: assert property (data_req |=> data_ack)
    else $error("data access not answered next cycle");
  a_data_ack_cause: assert property (data_ack |-> $past(data_req))
    else $error("data answer without request");
  // claim decode of the data space
  a_window_claim: assert property (data_req && in_win |=> data_claim)
    else $error("window address not claimed");
  a_register_claim: assert property (data_req && in_reg |=> data_claim)
    else $error("mapping register not claimed");
  a_other_unclaimed: assert property (data_req && !in_win && !in_reg |=> !data_claim)
    else $error("foreign address claimed");
  a_unclaimed_filler: assert property (data_req && !data_we && !in_win |=> data_rdata == 8'hff)
    else $error("read outside window returned rom data");
  // upper half never faults, faults return filler
  a_static_no_fault: assert property (fetch_req && program_counter[11] |=> !fetch_fault)
    else $error("static fetch reported a fault");
  a_fault_filler: assert property (fetch_ack && fetch_fault |-> fetch_data == 8'hff)
    else $error("faulted fetch returned rom data");
  // main scenarios reached
  c_fault: cover property (fetch_ack && fetch_fault);
  c_window_read: cover property (data_req && in_win && !data_we);
  c_page_write: cover property (data_req && data_we && data_addr == rbdw_pkg::PAGE_REG_ADDR);
endmodule : rbdw_link_properties

// [bench/rbdw_tb_top.sv]
// self-checking bench joining the core end and the mapping end over the link
// assumes the package, interface and design files under hw/ are compiled first
`timescale 1ns/1ns
module rbdw_tb_top;
  typedef struct packed {
    logic [1:0] op;
    logic [11:0] a;
    logic [7:0] d;
    logic [15:0] x;
  } rbdw_row_t;
  localparam logic [1:0] OF = rbdw_pkg::OP_FETCH;
  localparam logic [1:0] OR = rbdw_pkg::OP_READ;
  localparam logic [1:0] OW = rbdw_pkg::OP_WRITE;
  // op, address, write data, physical rom address (bit 15 means filler byte)
  localparam rbdw_row_t ROWS [16] = '{
    '{OF, 12'h800, 8'h00, 16'h0800}, '{OW, 12'h0ca, 8'h03, 16'h0000},
    '{OF, 12'h123, 8'h00, 16'h1923}, '{OF, 12'h9ab, 8'h00, 16'h09ab},
    '{OW, 12'h0ca, 8'h01, 16'h0000}, '{OF, 12'h456, 8'h00, 16'h0c56},
    '{OF, 12'hc56, 8'h00, 16'h0c56}, '{OW, 12'h0c9, 8'h05, 16'h0000},
    '{OR, 12'h040, 8'h00, 16'h0140}, '{OR, 12'h07f, 8'h00, 16'h017f},
    '{OW, 12'h0c9, 8'hff, 16'h0000}, '{OR, 12'h06a, 8'h00, 16'h3fea},
    '{OW, 12'h040, 8'h55, 16'h0000}, '{OR, 12'h06a, 8'h00, 16'h3fea},
    '{OR, 12'h080, 8'h00, 16'h8000}, '{OR, 12'h0c9, 8'h00, 16'h8000}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rom_load_en = 1'b0;
  logic [14:0] rom_load_addr = 15'h0;
  logic [7:0] rom_load_data = 8'h00;
  logic [3:0] page_code;
  logic [7:0] win_base;
  logic page_ld;
  logic win_ld;
  logic test_hit;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  rbdw_if link ();
  rbdw_dev u_rbdw_dev (.pclk(pclk), .presetn(presetn), .link(link.dev),
    .rom_load_en(rom_load_en), .rom_load_addr(rom_load_addr), .rom_load_data(rom_load_data),
    .page_code_bits(page_code), .window_base_bits(win_base), .page_loaded(page_ld),
    .window_loaded(win_ld), .test_area_hit(test_hit));
  rbdw_core_end u_rbdw_core_end (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.core));
  rbdw_link_properties u_rbdw_link_properties (.pclk(pclk), .presetn(presetn),
    .fetch_req(link.fetch_req), .program_counter(link.program_counter),
    .fetch_ack(link.fetch_ack), .fetch_data(link.fetch_data), .fetch_fault(link.fetch_fault),
    .data_req(link.data_req), .data_we(link.data_we), .data_addr(link.data_addr),
    .data_rdata(link.data_rdata), .data_ack(link.data_ack), .data_claim(link.data_claim));
  // 25 mhz clock
  always #20 pclk = ~pclk;
  // rom image pattern, distinct per page
  function automatic logic [7:0] rom_byte(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction : rom_byte
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("counts: checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one order: address, data, control, poll busy, fetch result
  task automatic do_op(input logic [1:0] op, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic [31:0] st);
    logic e;
    int n;
    apb(1'b1, rbdw_pkg::ADDR_OFS, {20'h0, a}, rd, e);
    apb(1'b1, rbdw_pkg::WDATA_OFS, {24'h0, d}, rd, e);
    apb(1'b1, rbdw_pkg::CTRL_OFS, {30'h0, op}, rd, e);
    n = 0;
    st = 32'h1;
    while (st[rbdw_pkg::STAT_BUSY] !== 1'b0 && n < 20) begin
      apb(1'b0, rbdw_pkg::STATUS_OFS, 32'h0, st, e);
      n++;
    end
    check({31'h0, st[rbdw_pkg::STAT_BUSY]}, 32'h0);
    apb(1'b0, rbdw_pkg::RDATA_OFS, 32'h0, rd, e);
  endtask : do_op
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    rbdw_row_t row;
    logic [31:0] rd;
    logic [31:0] st;
    logic e;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({page_code, win_base, page_ld, win_ld}, 32'h0);
    for (int i = 0; i < rbdw_pkg::ROM_BYTES; i++) begin
      rom_load_en <= 1'b1;
      rom_load_addr <= i[14:0];
      rom_load_data <= rom_byte(i[14:0]);
      @(posedge pclk);
    end
    rom_load_en <= 1'b0;
    $display("test reset and load done");
    for (int k = 0; k < 16; k++) begin
      row = ROWS[k];
      do_op(row.op, row.a, row.d, rd, st);
      if (row.op != OW) check(rd[7:0], row.x[15] ? 8'hff : rom_byte(row.x[14:0]));
    end
    $display("test table done");
    for (int p = 0; p < 10; p++) begin
      do_op(OF, 12'h800, 8'h00, rd, st);
      do_op(OW, 12'h0ca, p[7:0], rd, st);
      do_op(OF, 12'h2a5, 8'h00, rd, st);
      check(rd[7:0], rom_byte({p[3:0], 11'h2a5}));
    end
    $display("test page codes done");
    do_op(OF, 12'h6ac, 8'h00, rd, st);
    check(test_hit, 1'b1);
    do_op(OF, 12'h6ab, 8'h00, rd, st);
    check(test_hit, 1'b0);
    do_op(OW, 12'h0ca, 8'h02, rd, st);
    check({st[rbdw_pkg::STAT_REFUSED], page_code}, 5'h19);
    do_op(rbdw_pkg::OP_CODE_BAD, 12'h800, 8'h00, rd, st);
    check(st[rbdw_pkg::STAT_REFUSED], 1'b1);
    $display("test test area and refusals done");
    do_op(OF, 12'h800, 8'h00, rd, st);
    do_op(OW, 12'h0ca, 8'hf3, rd, st);
    check(page_code, 4'h3);
    do_op(OW, 12'h0ca, 8'h0a, rd, st);
    do_op(OF, 12'h100, 8'h00, rd, st);
    check({st[rbdw_pkg::STAT_FAULT], rd[7:0]}, 9'h1ff);
    apb(1'b0, rbdw_pkg::IMAGE_OFS, 32'h0, rd, e);
    check(rd[15:0], 16'hff0a);
    check({page_ld, win_ld}, 2'b11);
    check(win_base, 8'hff);
    apb(1'b1, rbdw_pkg::IMAGE_OFS, 32'h0000_5a07, rd, e);
    apb(1'b0, rbdw_pkg::IMAGE_OFS, 32'h0, rd, e);
    check(rd[15:0], 16'h5a07);
    do_op(OR, 12'h040, 8'h00, rd, st);
    check({st[rbdw_pkg::STAT_CLAIM], rd[7:0]}, {1'b1, rom_byte(15'h3fc0)});
    apb(1'b0, 8'h18, 32'h0, rd, e);
    check(e, 1'b1);
    $display("test fault, image and unmapped done");
    presetn <= 1'b0;
    @(posedge pclk);
    check({page_code, win_base, page_ld, win_ld}, 32'h0);
    presetn <= 1'b1;
    do_op(OF, 12'h9ab, 8'h00, rd, st);
    check(rd[7:0], rom_byte(15'h09ab));
    $display("test second reset done");
    final_report();
  end
endmodule : rbdw_tb_top
